// ### dcc_pkg.sv
// Register map, field layout, reset values and decode helpers.
// Contract
// - Readback bit 5 shows live comparator one.
// - Readback bit 4 shows live comparator zero.
// - Readback bit 1 shows latch one.
// - Readback bit 0 shows latch zero.
// - Positive select decodes bus, line1, line3.
// - Negative select decodes main, low, high.
// - Enable bits power each comparator.
// - Interrupt select one routes rising edges.
// - Interrupt select zero routes rising edges.
// - Both sources share one interrupt.
// - Pin source one picks function or latch.
// - Pin source zero picks function or latch.
// - Clear source one picks software or edge.
// - Clear source zero picks software or edge.
// - Data source one picks function or latch.
// - Data source zero picks function or latch.
// - Sixteen logic functions of both outputs.
package dcc_pkg;

  localparam int ADDR_W = 10;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_READBACK = 8'h78;
  localparam logic [7:0] IDX_INPUT_SELECT = 8'h79;
  localparam logic [7:0] IDX_ENABLE = 8'h7A;
  localparam logic [7:0] IDX_OUTPUT_CONTROL = 8'h7B;
  localparam logic [7:0] IDX_LOGIC_FUNC = 8'h7C;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h7D;

  // Readback fields.
  localparam int RB_LIVE_ONE = 5;
  localparam int RB_LIVE_ZERO = 4;
  localparam int RB_LATCH_ONE = 1;
  localparam int RB_LATCH_ZERO = 0;

  // Input select fields.
  localparam int POS_ONE_LSB = 6;
  localparam int NEG_ONE_LSB = 4;
  localparam int POS_ZERO_LSB = 2;
  localparam int NEG_ZERO_LSB = 0;

  // Enable fields.
  localparam int EN_ONE = 4;
  localparam int EN_ZERO = 0;

  // Output control fields.
  localparam int OC_IRQ_SEL_ONE = 7;
  localparam int OC_PIN_SRC_ONE = 6;
  localparam int OC_CLEAR_SRC_ONE = 5;
  localparam int OC_DATA_SRC_ONE = 4;
  localparam int OC_IRQ_SEL_ZERO = 3;
  localparam int OC_PIN_SRC_ZERO = 2;
  localparam int OC_CLEAR_SRC_ZERO = 1;
  localparam int OC_DATA_SRC_ZERO = 0;

  // Logic function and interrupt enable fields.
  localparam int LF_ONE_LSB = 4;
  localparam int LF_ZERO_LSB = 0;
  localparam int IE_UNMASK = 0;

  // Reset values.
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_OUTPUT_CONTROL = 8'h00;
  localparam logic [7:0] RST_LOGIC_FUNC = 8'h00;
  localparam logic RST_IRQ_ENABLE = 1'b0;

  typedef enum logic [1:0] {
    POS_GLOBAL_BUS = 2'h0,
    POS_RESERVED = 2'h1,
    POS_PORT0_LINE1 = 2'h2,
    POS_PORT0_LINE3 = 2'h3
  } dcc_pos_t;

  typedef enum logic [1:0] {
    NEG_MAIN_REF = 2'h0,
    NEG_LOW_REF = 2'h1,
    NEG_HIGH_REF = 2'h2,
    NEG_RESERVED = 2'h3
  } dcc_neg_t;

  // One-hot switch enables {line3, line1, global bus}; reserved opens all.
  function automatic logic [2:0] decode_pos(input logic [1:0] code);
    case (dcc_pos_t'(code))
      POS_GLOBAL_BUS: decode_pos = 3'h1;
      POS_PORT0_LINE1: decode_pos = 3'h2;
      POS_PORT0_LINE3: decode_pos = 3'h4;
      default: decode_pos = 3'h0;
    endcase
  endfunction : decode_pos

  // One-hot switch enables {high, low, main}; reserved opens all.
  function automatic logic [2:0] decode_neg(input logic [1:0] code);
    case (dcc_neg_t'(code))
      NEG_MAIN_REF: decode_neg = 3'h1;
      NEG_LOW_REF: decode_neg = 3'h2;
      NEG_HIGH_REF: decode_neg = 3'h4;
      default: decode_neg = 3'h0;
    endcase
  endfunction : decode_neg

  // Code bit 0 covers A=1,B=1 and bit 3 covers A=0,B=0.
  function automatic logic logic_func(input logic [3:0] code,
                                      input logic a, input logic b);
    logic_func = code[{~a, ~b}];
  endfunction : logic_func

endpackage : dcc_pkg

// ### dcc_sync.sv
// Two-stage synchroniser for one asynchronous comparator output.
`timescale 1ns/1ps
module dcc_sync (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data.
  input wire logic async_in,
  output logic sync_out
);

  logic stage_one;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule : dcc_sync

// ### dcc_channel.sv
// One comparator channel: logic function, latch and output selection.
`timescale 1ns/1ps
module dcc_channel (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Comparator levels, gated by enable.
  input wire logic live_self,
  input wire logic live_other,
  // Controls.
  input wire logic [3:0] func_code,
  input wire logic clear_src,
  input wire logic sw_clear,
  input wire logic pin_src,
  input wire logic data_src,
  input wire logic irq_sel,
  input wire logic other_func_rise,
  // Results.
  output logic func_out,
  output logic func_rise,
  output logic latch_out,
  output logic pin_sig,
  output logic sense_data,
  output logic irq_event
);

  logic func_q;
  logic sense_q;
  logic clear_now;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      func_out <= 1'b0;
      func_q <= 1'b0;
    end else begin
      func_out <= dcc_pkg::logic_func(func_code, live_self,
                                      live_other);
      func_q <= func_out;
    end
  end

  assign func_rise = func_out & ~func_q;

  // Software clears count only while software clearing is selected.
  assign clear_now = clear_src ? other_func_rise
                               : sw_clear;

  // A high output in the clearing cycle keeps the latch set.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch_out <= 1'b0;
    end else if (live_self) begin
      latch_out <= 1'b1;
    end else if (clear_now) begin
      latch_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_sig <= 1'b0;
      sense_data <= 1'b0;
      sense_q <= 1'b0;
    end else begin
      pin_sig <= pin_src ? latch_out : func_out;
      sense_data <= data_src ? latch_out : func_out;
      sense_q <= sense_data;
    end
  end

  assign irq_event = irq_sel & sense_data & ~sense_q;

endmodule : dcc_channel

// ### dcc_top.sv
// Comparator control block with its Avalon-MM register slave.
`timescale 1ns/1ps
module dcc_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM slave.
  input wire logic [dcc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Raw comparator outputs from the analog side.
  input wire logic comp_raw_one,
  input wire logic comp_raw_zero,
  // Analog controls.
  output logic power_on_one,
  output logic power_on_zero,
  output logic [2:0] pos_route_one,
  output logic [2:0] neg_route_one,
  output logic [2:0] pos_route_zero,
  output logic [2:0] neg_route_zero,
  // Routed comparator signals.
  output logic pin_sig_one,
  output logic pin_sig_zero,
  output logic sense_data_one,
  output logic sense_data_zero,
  output logic analog_irq
);

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } dcc_bus_t;

  dcc_bus_t bus_state;
  dcc_bus_t next_bus_state;

  logic [7:0] input_select;
  logic [7:0] enable_bits;
  logic [7:0] output_control;
  logic [7:0] logic_func_select;
  logic irq_unmask;

  logic [1:0] raw_cmp;
  logic [1:0] sync_cmp;
  logic [1:0] live_cmp;
  logic [1:0] en_cmp;
  logic [1:0] func_out;
  logic [1:0] func_rise;
  logic [1:0] latch_out;
  logic [1:0] pin_sig;
  logic [1:0] sense_data;
  logic [1:0] irq_event;
  logic [1:0] sw_clear;
  logic [1:0] clear_src;
  logic [1:0] pin_src;
  logic [1:0] data_src;
  logic [1:0] irq_sel;
  logic [3:0] func_code [2];

  logic [7:0] reg_index;
  logic addr_aligned;
  logic commit_write;
  logic lane_zero;
  logic [7:0] wbyte;

  // Index 1 is comparator one, index 0 is comparator zero.
  assign raw_cmp = {comp_raw_one, comp_raw_zero};
  assign en_cmp[1] = enable_bits[dcc_pkg::EN_ONE];
  assign en_cmp[0] = enable_bits[dcc_pkg::EN_ZERO];
  assign clear_src[1] = output_control[dcc_pkg::OC_CLEAR_SRC_ONE];
  assign clear_src[0] = output_control[dcc_pkg::OC_CLEAR_SRC_ZERO];
  assign pin_src[1] = output_control[dcc_pkg::OC_PIN_SRC_ONE];
  assign pin_src[0] = output_control[dcc_pkg::OC_PIN_SRC_ZERO];
  assign data_src[1] = output_control[dcc_pkg::OC_DATA_SRC_ONE];
  assign data_src[0] = output_control[dcc_pkg::OC_DATA_SRC_ZERO];
  assign irq_sel[1] = output_control[dcc_pkg::OC_IRQ_SEL_ONE];
  assign irq_sel[0] = output_control[dcc_pkg::OC_IRQ_SEL_ZERO];
  assign func_code[1] = logic_func_select[dcc_pkg::LF_ONE_LSB +: 4];
  assign func_code[0] = logic_func_select[dcc_pkg::LF_ZERO_LSB +: 4];

  // A disabled comparator is powered off and reads as low.
  assign live_cmp = sync_cmp & en_cmp;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      dcc_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(raw_cmp[gi]),
        .sync_out(sync_cmp[gi])
      );

      dcc_channel u_chan (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .live_self(live_cmp[gi]),
        .live_other(live_cmp[1-gi]),
        .func_code(func_code[gi]),
        .clear_src(clear_src[gi]),
        .sw_clear(sw_clear[gi]),
        .pin_src(pin_src[gi]),
        .data_src(data_src[gi]),
        .irq_sel(irq_sel[gi]),
        .other_func_rise(func_rise[1-gi]),
        .func_out(func_out[gi]),
        .func_rise(func_rise[gi]),
        .latch_out(latch_out[gi]),
        .pin_sig(pin_sig[gi]),
        .sense_data(sense_data[gi]),
        .irq_event(irq_event[gi])
      );
    end
  endgenerate

  // Bus decode.
  assign reg_index = avs_address[9:2];
  assign addr_aligned = (avs_address[1:0] == 2'h0);
  assign lane_zero = avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // Writes land at the edge where waitrequest is seen low.
  assign commit_write = (bus_state == BUS_ANSWER) && avs_write &&
                        addr_aligned && lane_zero;

  // Only a written zero clears; a written one is ignored.
  assign sw_clear[1] = commit_write &&
                       (reg_index == dcc_pkg::IDX_READBACK) &&
                       !wbyte[dcc_pkg::RB_LATCH_ONE];
  assign sw_clear[0] = commit_write &&
                       (reg_index == dcc_pkg::IDX_READBACK) &&
                       !wbyte[dcc_pkg::RB_LATCH_ZERO];

  // Bus handshake: one wait cycle, then a single answer cycle.
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_bus_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= (next_bus_state != BUS_ANSWER);
    end
  end

  // Read data is captured one edge before it is taken.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_state == BUS_IDLE && avs_read) begin
      avs_readdata <= 32'h0000_0000;
      if (addr_aligned) begin
        case (reg_index)
          dcc_pkg::IDX_READBACK: begin
            avs_readdata[dcc_pkg::RB_LIVE_ONE] <= live_cmp[1];
            avs_readdata[dcc_pkg::RB_LIVE_ZERO] <= live_cmp[0];
            avs_readdata[dcc_pkg::RB_LATCH_ONE] <= latch_out[1];
            avs_readdata[dcc_pkg::RB_LATCH_ZERO] <= latch_out[0];
          end
          dcc_pkg::IDX_INPUT_SELECT: begin
            avs_readdata[7:0] <= input_select;
          end
          dcc_pkg::IDX_ENABLE: begin
            avs_readdata[7:0] <= enable_bits;
          end
          dcc_pkg::IDX_OUTPUT_CONTROL: begin
            avs_readdata[7:0] <= output_control;
          end
          dcc_pkg::IDX_LOGIC_FUNC: begin
            avs_readdata[7:0] <= logic_func_select;
          end
          dcc_pkg::IDX_IRQ_ENABLE: begin
            avs_readdata[dcc_pkg::IE_UNMASK] <= irq_unmask;
          end
          default: begin
            avs_readdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Input selection register.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      input_select <= dcc_pkg::RST_INPUT_SELECT;
    end else if (commit_write &&
                 reg_index == dcc_pkg::IDX_INPUT_SELECT) begin
      input_select <= wbyte;
    end
  end

  // Enable register; reserved bits are not stored and read as zero.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable_bits <= dcc_pkg::RST_ENABLE;
    end else if (commit_write && reg_index == dcc_pkg::IDX_ENABLE) begin
      enable_bits <= 8'h00;
      enable_bits[dcc_pkg::EN_ONE] <= wbyte[dcc_pkg::EN_ONE];
      enable_bits[dcc_pkg::EN_ZERO] <= wbyte[dcc_pkg::EN_ZERO];
    end
  end

  // Output control register.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      output_control <= dcc_pkg::RST_OUTPUT_CONTROL;
    end else if (commit_write &&
                 reg_index == dcc_pkg::IDX_OUTPUT_CONTROL) begin
      output_control <= wbyte;
    end
  end

  // Logic function codes for both channels.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      logic_func_select <= dcc_pkg::RST_LOGIC_FUNC;
    end else if (commit_write &&
                 reg_index == dcc_pkg::IDX_LOGIC_FUNC) begin
      logic_func_select <= wbyte;
    end
  end

  // Analog interrupt mask.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_unmask <= dcc_pkg::RST_IRQ_ENABLE;
    end else if (commit_write &&
                 reg_index == dcc_pkg::IDX_IRQ_ENABLE) begin
      irq_unmask <= wbyte[dcc_pkg::IE_UNMASK];
    end
  end

  // Power and input switch drives.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_on_one <= 1'b0;
      power_on_zero <= 1'b0;
    end else begin
      power_on_one <= en_cmp[1];
      power_on_zero <= en_cmp[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pos_route_one <= 3'h0;
      pos_route_zero <= 3'h0;
    end else begin
      pos_route_one <= dcc_pkg::decode_pos(
        input_select[dcc_pkg::POS_ONE_LSB +: 2]);
      pos_route_zero <= dcc_pkg::decode_pos(
        input_select[dcc_pkg::POS_ZERO_LSB +: 2]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      neg_route_one <= 3'h0;
      neg_route_zero <= 3'h0;
    end else begin
      neg_route_one <= dcc_pkg::decode_neg(
        input_select[dcc_pkg::NEG_ONE_LSB +: 2]);
      neg_route_zero <= dcc_pkg::decode_neg(
        input_select[dcc_pkg::NEG_ZERO_LSB +: 2]);
    end
  end

  // Routed signals, re-registered at the boundary.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_sig_one <= 1'b0;
      pin_sig_zero <= 1'b0;
    end else begin
      pin_sig_one <= pin_sig[1];
      pin_sig_zero <= pin_sig[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sense_data_one <= 1'b0;
      sense_data_zero <= 1'b0;
    end else begin
      sense_data_one <= sense_data[1];
      sense_data_zero <= sense_data[0];
    end
  end

  // Either selected source raises the one shared interrupt pulse.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      analog_irq <= 1'b0;
    end else begin
      analog_irq <= irq_unmask && (|irq_event);
    end
  end

endmodule : dcc_top

// ### dcc_monitor.sv
// Port-level assertions for the comparator control block.
`timescale 1ns/1ps
module dcc_monitor (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus.
  input wire logic [dcc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Analog controls and routed signals.
  input wire logic power_on_one,
  input wire logic power_on_zero,
  input wire logic [2:0] pos_route_one,
  input wire logic [2:0] neg_route_one,
  input wire logic [2:0] pos_route_zero,
  input wire logic [2:0] neg_route_zero,
  input wire logic sense_data_one,
  input wire logic sense_data_zero,
  input wire logic analog_irq
);
  localparam logic [9:0] A_RB = {dcc_pkg::IDX_READBACK, 2'h0};
  localparam logic [9:0] A_MUX = {dcc_pkg::IDX_INPUT_SELECT, 2'h0};
  localparam logic [9:0] A_EN = {dcc_pkg::IDX_ENABLE, 2'h0};
  localparam logic [9:0] A_OC = {dcc_pkg::IDX_OUTPUT_CONTROL, 2'h0};
  localparam logic [9:0] A_IE = {dcc_pkg::IDX_IRQ_ENABLE, 2'h0};
  logic commit, rd_ans, un_v;
  logic [1:0] en_d, mux_d;
  logic [7:0] en_v, mux_v, oc_v;
  logic [2:0] p1, n1, p0, n0;
  assign commit = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_ans = avs_read && !avs_waitrequest;
  assign p1 = {mux_v[7:6] == 2'h3, mux_v[7:6] == 2'h2, mux_v[7:6] == 2'h0};
  assign n1 = {mux_v[5:4] == 2'h2, mux_v[5:4] == 2'h1, mux_v[5:4] == 2'h0};
  assign p0 = {mux_v[3:2] == 2'h3, mux_v[3:2] == 2'h2, mux_v[3:2] == 2'h0};
  assign n0 = {mux_v[1:0] == 2'h2, mux_v[1:0] == 2'h1, mux_v[1:0] == 2'h0};
  // Shadow copies of what software last wrote, with settle delays.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_d <= 2'h0;
      mux_d <= 2'h0;
      en_v <= 8'h00;
      mux_v <= 8'h00;
      oc_v <= 8'h00;
      un_v <= 1'b0;
    end else begin
      en_d <= {en_d[0], commit && avs_address == A_EN};
      mux_d <= {mux_d[0], commit && avs_address == A_MUX};
      if (commit && avs_address == A_EN) en_v <= avs_writedata[7:0];
      if (commit && avs_address == A_MUX) mux_v <= avs_writedata[7:0];
      if (commit && avs_address == A_OC) oc_v <= avs_writedata[7:0];
      if (commit && avs_address == A_IE) un_v <= avs_writedata[0];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  chk_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_readback_rsvd: assert property (
    rd_ans && avs_address == A_RB |-> (avs_readdata & 32'hFFFFFFCC) == 32'h0)
    else $error("readback shows a reserved bit");
  chk_enable_rsvd: assert property (
    rd_ans && avs_address == A_EN |-> (avs_readdata & 32'hFFFFFFEE) == 32'h0)
    else $error("enable shows a reserved bit");
  chk_unmapped_zero: assert property (
    rd_ans && (avs_address[1:0] != 2'h0 || avs_address < A_RB ||
    avs_address > A_IE) |-> avs_readdata == 32'h0)
    else $error("unmapped read returned data");
  chk_power_value: assert property (
    en_d[1] |-> power_on_one == en_v[4] && power_on_zero == en_v[0])
    else $error("power controls differ from enable bits");
  chk_route_value: assert property (
    mux_d[1] |-> pos_route_one == p1 && neg_route_one == n1 &&
    pos_route_zero == p0 && neg_route_zero == n0)
    else $error("input switches differ from select code");
  chk_irq_source: assert property (
    analog_irq |-> un_v && ((oc_v[3] && $rose(sense_data_zero)) ||
    (oc_v[7] && $rose(sense_data_one))))
    else $error("interrupt without a selected rising source");
  chk_irq_pulse: assert property (analog_irq |=> !analog_irq)
    else $error("interrupt longer than one cycle");
endmodule : dcc_monitor

bind dcc_top dcc_monitor i_mon (.clk_sys, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .power_on_one, .power_on_zero, .pos_route_one,
  .neg_route_one, .pos_route_zero, .neg_route_zero, .sense_data_one,
  .sense_data_zero, .analog_irq);

// ### dcc_analog_model.sv
// Behavioural pair of comparators behind their input switches.
`timescale 1ns/1ps
module dcc_analog_model (
  // Clock.
  input wire logic clk_sys,
  // Controls from the block.
  input wire logic power_on_one,
  input wire logic power_on_zero,
  input wire logic [2:0] pos_route_one,
  input wire logic [2:0] neg_route_one,
  input wire logic [2:0] pos_route_zero,
  input wire logic [2:0] neg_route_zero,
  // Comparison results wanted by the bench.
  input wire logic lvl_one,
  input wire logic lvl_zero,
  // Raw outputs.
  output logic comp_raw_one,
  output logic comp_raw_zero
);
  logic junk = 1'b0;
  // An unpowered or unrouted comparator gives a level that means nothing.
  always @(posedge clk_sys) junk <= ~junk;
  assign comp_raw_one = (power_on_one && |pos_route_one && |neg_route_one)
    ? lvl_one : junk;
  assign comp_raw_zero = (power_on_zero && |pos_route_zero &&
    |neg_route_zero) ? lvl_zero : junk;
endmodule : dcc_analog_model

// ### tb.sv
// Self-checking bench for the comparator control block.
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [dcc_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, comp_raw_one, comp_raw_zero;
  logic lvl_one = 1'b0, lvl_zero = 1'b0;
  logic power_on_one, power_on_zero, analog_irq;
  logic [2:0] pos_route_one, neg_route_one, pos_route_zero, neg_route_zero;
  logic pin_sig_one, pin_sig_zero, sense_data_one, sense_data_zero;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h9AEF;
  logic [3:0] cd;
  logic f0, f1;
  int bad_count = 0, n_tests = 0, cyc = 0, irq_n = 0, n0;

  initial forever #2.5 clk_sys = ~clk_sys;

  dcc_top i_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .comp_raw_one, .comp_raw_zero, .power_on_one, .power_on_zero,
    .pos_route_one, .neg_route_one, .pos_route_zero, .neg_route_zero,
    .pin_sig_one, .pin_sig_zero, .sense_data_one, .sense_data_zero,
    .analog_irq);
  dcc_analog_model i_model (.clk_sys, .power_on_one, .power_on_zero,
    .pos_route_one, .neg_route_one, .pos_route_zero, .neg_route_zero,
    .lvl_one, .lvl_zero, .comp_raw_one, .comp_raw_zero);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One bus transfer, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= {idx, 2'h0};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 8'h00);
  endtask : rd

  task automatic lv(input logic a, input logic b);
    lvl_zero <= a;
    lvl_one <= b;
    repeat (10) @(posedge clk_sys);
  endtask : lv

  task automatic chk4(input logic e0, input logic e1);
    check("pin_sig_zero", 32'(pin_sig_zero), 32'(e0));
    check("sense_data_zero", 32'(sense_data_zero), 32'(e0));
    check("pin_sig_one", 32'(pin_sig_one), 32'(e1));
    check("sense_data_one", 32'(sense_data_one), 32'(e1));
  endtask : chk4

  // Watcher: read answers against queued notes, interrupt count, timeout.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (analog_irq === 1'b1) irq_n <= irq_n + 1;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      check("readdata", avs_readdata, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 8'h78; i < 8'h80; i++) rd(8'(i), 32'h0);
    for (int c = 0; c < 4; c++) wr(dcc_pkg::IDX_INPUT_SELECT, {4{2'(c)}});
    seed = xs(seed);
    wr(dcc_pkg::IDX_INPUT_SELECT, seed[7:0]);
    rd(dcc_pkg::IDX_INPUT_SELECT, {24'h0, seed[7:0]});
    seed = xs(seed);
    wr(dcc_pkg::IDX_ENABLE, seed[7:0] & 8'h11);
    rd(dcc_pkg::IDX_ENABLE, {24'h0, seed[7:0] & 8'h11});
    wr(dcc_pkg::IDX_INPUT_SELECT, 8'h00);
    wr(dcc_pkg::IDX_ENABLE, 8'h11);
    lv(1'b1, 1'b1);
    rd(dcc_pkg::IDX_READBACK, 32'h33);
    lv(1'b0, 1'b0);
    rd(dcc_pkg::IDX_READBACK, 32'h03);
    wr(dcc_pkg::IDX_READBACK, 8'h03);
    rd(dcc_pkg::IDX_READBACK, 32'h03);
    wr(dcc_pkg::IDX_READBACK, 8'h02);
    rd(dcc_pkg::IDX_READBACK, 32'h02);
    wr(dcc_pkg::IDX_READBACK, 8'h00);
    rd(dcc_pkg::IDX_READBACK, 32'h00);
    wr(dcc_pkg::IDX_ENABLE, 8'h01);
    lv(1'b0, 1'b1);
    rd(dcc_pkg::IDX_READBACK, 32'h00);
    lv(1'b0, 1'b0);
    wr(dcc_pkg::IDX_ENABLE, 8'h11);
    wr(dcc_pkg::IDX_LOGIC_FUNC, 8'h33);
    wr(dcc_pkg::IDX_OUTPUT_CONTROL, 8'h22);
    lv(1'b1, 1'b0);
    lv(1'b0, 1'b0);
    wr(dcc_pkg::IDX_READBACK, 8'h00);
    rd(dcc_pkg::IDX_READBACK, 32'h01);
    lv(1'b0, 1'b1);
    lv(1'b0, 1'b0);
    rd(dcc_pkg::IDX_READBACK, 32'h02);
    lv(1'b1, 1'b0);
    lv(1'b0, 1'b0);
    rd(dcc_pkg::IDX_READBACK, 32'h01);
    wr(dcc_pkg::IDX_OUTPUT_CONTROL, 8'h00);
    for (int c = 0; c < 16; c++) begin
      cd = 4'(c);
      wr(dcc_pkg::IDX_LOGIC_FUNC, {cd, cd});
      for (int k = 0; k < 4; k++) begin
        lv(k[0], k[1]);
        f0 = cd[{!k[0], !k[1]}];
        f1 = cd[{!k[1], !k[0]}];
        chk4(f0, f1);
      end
    end
    lv(1'b0, 1'b0);
    wr(dcc_pkg::IDX_LOGIC_FUNC, 8'h00);
    wr(dcc_pkg::IDX_OUTPUT_CONTROL, 8'h55);
    rd(dcc_pkg::IDX_OUTPUT_CONTROL, 32'h55);
    lv(1'b1, 1'b1);
    lv(1'b0, 1'b0);
    chk4(1'b1, 1'b1);
    wr(dcc_pkg::IDX_READBACK, 8'h00);
    lv(1'b0, 1'b0);
    chk4(1'b0, 1'b0);
    wr(dcc_pkg::IDX_LOGIC_FUNC, 8'h33);
    for (int k = 0; k < 16; k++) begin
      wr(dcc_pkg::IDX_IRQ_ENABLE, 8'(k[3]));
      wr(dcc_pkg::IDX_OUTPUT_CONTROL, {k[2], 3'h0, k[1], 3'h0});
      n0 = irq_n;
      lv(!k[0], k[0]);
      lv(1'b0, 1'b0);
      f0 = k[3] && k[1 + k[0]];
      check("irq_count", irq_n - n0, 32'(f0));
    end
    summarize();
  end
endmodule : tb
